// File: verilog/mon_defines.svh
// Offsets, field positions, reset values and timing of the monitor register bank
`ifndef MON_DEFINES_SVH
`define MON_DEFINES_SVH
// ------------------------------------------------------------
// Register indices; byte address is four times the index
// ------------------------------------------------------------
`define IDX_W 6
`define IDX_RESULT 6'h01
`define IDX_CODE_A 6'h01
`define IDX_CODE_D 6'h04
`define IDX_DIODE_ONE 6'h02
`define IDX_DIODE_TWO 6'h03
`define IDX_INTERNAL 6'h04
`define IDX_ALERT_A 6'h05
`define IDX_ALERT_B 6'h06
`define IDX_ALERT_C 6'h07
`define IDX_SEQ 6'h08
`define IDX_CFG 6'h09
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define CODE_W 12
`define TEMP_W 11
`define SEQ_W 6
`define CFG_RESET 16'h0000
`define CFG_BIT_CLR 1
`define CFG_BIT_PIN 2
`define CFG_BIT_AUTO 12
`define ALERT_B_MASK 8'h3f
`define CHID_DIODE_ONE 3'b110
`define CHID_DIODE_TWO 3'b111
`define INT_PAD 4'h0
`define C_BIT_OVERTEMP 6
`define C_BIT_OPEN 7
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define REFRESH_US 5000
`define CLK_MHZ 40
`endif

// File: verilog/mon_pkg.sv
// Types shared by the monitor register bank modules
package mon_pkg;
  typedef struct packed {
    logic [2:0] flag;
    logic [1:0] open;
    logic [2:0][10:0] val;
    logic [2:0] req;
    logic [7:0] set;
  } temp_st_t;

  typedef struct packed {
    logic [23:0] status;
  } alert_st_t;

  typedef struct packed {
    logic aw_hold;
    logic [5:0] aw_idx;
    logic w_hold;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [3:0][11:0] code;
    logic [3:0] code_load;
    logic [5:0] seq;
    logic [15:0] cfg;
    logic [23:0] clr;
  } main_st_t;
endpackage

// File: verilog/mon_if.sv
// Carriers between the register bank and its temperature and alert units
`timescale 1ns/1ps
interface temp_if;
  logic [2:0][15:0] word;
  logic [7:0] set;
  modport unit (output word, set);
  modport bank (input word, set);
endinterface

interface alert_if;
  logic [23:0] set;
  logic [23:0] clr;
  logic [23:0] status;
  modport unit (input set, clr, output status);
  modport bank (output set, clr, input status);
endinterface

// File: verilog/temp_unit.sv
// Temperature result capture and periodic refresh request
`timescale 1ns/1ps
`include "mon_defines.svh"
module temp_unit import mon_pkg::*; #(
  parameter int REFRESH_CYCLES = `REFRESH_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Conversion results
  input wire logic conv_done_in,
  input wire logic [1:0] conv_chan_in,
  input wire logic [10:0] conv_value_in,
  input wire logic conv_low_in,
  input wire logic conv_high_in,
  input wire logic conv_open_in,
  input wire logic conv_overtemp_in,
  // Requests and results
  output logic [2:0] conv_request_out,
  temp_if.unit tif
);
  localparam int CW = $clog2(REFRESH_CYCLES);
  temp_st_t s, n;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic trip;

  // ------------------------------------------------------------
  // Capture and refresh
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    n.req = 3'h0;
    n.set = 8'h00;
    trip = conv_low_in | conv_high_in | conv_overtemp_in;
    // Each channel is asked for a fresh conversion once per period
    if (cnt_r == CW'(REFRESH_CYCLES - 1)) begin
      cnt_nxt = '0;
      n.req = 3'h7;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    if (conv_done_in && conv_chan_in != 2'h3) begin
      n.val[conv_chan_in] = conv_value_in;
      if (conv_chan_in != 2'h2) begin
        n.open[conv_chan_in[0]] = conv_open_in;
        trip = trip | conv_open_in;
        n.set[`C_BIT_OPEN] = conv_open_in;
      end
      // Flag and cause are recorded in the same cycle
      n.flag[conv_chan_in] = trip;
      n.set[{conv_chan_in, 1'b0}] = conv_low_in;
      n.set[{conv_chan_in, 1'b1}] = conv_high_in;
      n.set[`C_BIT_OVERTEMP] = conv_overtemp_in;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
      cnt_r <= '0;
    end else begin
      s <= n;
      cnt_r <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // Result words
  // ------------------------------------------------------------
  assign tif.word[0] = {s.flag[0], `CHID_DIODE_ONE, s.open[0], s.val[0]};
  assign tif.word[1] = {s.flag[1], `CHID_DIODE_TWO, s.open[1], s.val[1]};
  assign tif.word[2] = {s.flag[2], `INT_PAD, s.val[2]};
  assign tif.set = s.set;
  assign conv_request_out = s.req;
endmodule

// File: verilog/alert_unit.sv
// Sticky alert status for the three alert registers
`timescale 1ns/1ps
`include "mon_defines.svh"
module alert_unit import mon_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Events and clears
  alert_if.unit aif
);
  alert_st_t s, n;
  logic [23:0] mask;

  // ------------------------------------------------------------
  // Status update
  // ------------------------------------------------------------
  always_comb begin
    mask = {8'hff, `ALERT_B_MASK, 8'hff};
    // Bits stay until cleared; a new event beats a clear in the same cycle
    n.status = ((s.status & ~aif.clr) | aif.set) & mask;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign aif.status = s.status;
endmodule

// File: verilog/monitor_result_alert_regs.sv
// Monitor result, converter code and alert register bank on AXI4-Lite
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "mon_defines.svh"
module monitor_result_alert_regs import mon_pkg::*; #(
  parameter int REFRESH_CYCLES = `REFRESH_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // AXI4-Lite write address
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  // AXI4-Lite write data
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // AXI4-Lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // AXI4-Lite read address
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  // AXI4-Lite read data
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // Conversion results from the measurement path
  input wire logic conv_done_in,
  input wire logic [1:0] conv_chan_in,
  input wire logic [10:0] conv_value_in,
  input wire logic conv_low_in,
  input wire logic conv_high_in,
  input wire logic conv_open_in,
  input wire logic conv_overtemp_in,
  // Limit events of voltage and current channels
  input wire logic [7:0] volt_alert_in,
  input wire logic [5:0] curr_alert_in,
  // Temperature refresh requests
  output logic [2:0] conv_request_out,
  // Converter codes
  output logic [11:0] output_converter_a_out,
  output logic [11:0] output_converter_b_out,
  output logic [11:0] output_converter_c_out,
  output logic [11:0] output_converter_d_out,
  output logic [3:0] code_load_out,
  // Mode outputs
  output logic [5:0] channel_select_out,
  output logic [15:0] config_out,
  output logic autocycle_enable_out,
  output logic alert_pin_enable_out
);
  main_st_t s, n;
  temp_if tif();
  alert_if aif();
  logic [15:0] cfg_new;
  logic [15:0] code_new;
  logic [16:0] rd;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Merges the two byte lanes of a 16-bit word under their strobes
  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] strb
  );
    logic [15:0] r;
    r = old_v;
    if (strb[1]) begin
      r[15:8] = new_v[15:8];
    end
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    return r;
  endfunction

  // True for an index that lies in the bank
  function automatic logic idx_ok(input logic [5:0] idx);
    return idx >= `IDX_RESULT && idx <= `IDX_CFG;
  endfunction

  // True for an index whose write reaches a converter
  function automatic logic is_code_idx(input logic [5:0] idx);
    return idx >= `IDX_CODE_A && idx <= `IDX_CODE_D;
  endfunction

  // Converter slot of a write index, slot zero being converter A
  function automatic logic [1:0] code_slot(input logic [5:0] idx);
    return idx[1:0] - 2'd1;
  endfunction

  // Bits that a write clears in an 8-bit alert register; only lane 0 counts
  function automatic logic [7:0] clear_bits(
    input logic [15:0] data,
    input logic [1:0] strb,
    input logic [7:0] keep
  );
    logic [7:0] r;
    r = strb[0] ? data[7:0] : 8'h00;
    return r & keep;
  endfunction

  // Read word for an index, error in bit 16
  function automatic logic [16:0] rd_word(
    input logic [5:0] idx,
    input logic [2:0][15:0] tw,
    input logic [23:0] st,
    input logic [5:0] seq,
    input logic [15:0] cfg
  );
    logic [16:0] r;
    r = 17'h00000;
    unique case (idx)
      `IDX_DIODE_ONE: begin
        r[15:0] = tw[0];
      end
      `IDX_DIODE_TWO: begin
        r[15:0] = tw[1];
      end
      `IDX_INTERNAL: begin
        r[15:0] = tw[2];
      end
      `IDX_ALERT_A: begin
        r[7:0] = st[7:0];
      end
      `IDX_ALERT_B: begin
        r[7:0] = st[15:8];
      end
      `IDX_ALERT_C: begin
        r[7:0] = st[23:16];
      end
      `IDX_SEQ: begin
        r[5:0] = seq;
      end
      `IDX_CFG: begin
        r[15:0] = cfg;
      end
      // The shared result register is served elsewhere; reads zero here
      `IDX_RESULT: begin
        r[15:0] = 16'h0000;
      end
      default: begin
        r[16] = 1'b1;
      end
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // Units
  // ------------------------------------------------------------
  // Results and refresh requests of the three temperature channels
  temp_unit #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
  ) u_temp (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .conv_done_in(conv_done_in),
    .conv_chan_in(conv_chan_in),
    .conv_value_in(conv_value_in),
    .conv_low_in(conv_low_in),
    .conv_high_in(conv_high_in),
    .conv_open_in(conv_open_in),
    .conv_overtemp_in(conv_overtemp_in),
    .conv_request_out(conv_request_out),
    .tif(tif.unit)
  );

  // One sticky store holds all 24 alert bits
  alert_unit u_alert (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .aif(aif.unit)
  );

  // Events of all three registers meet in one sticky store
  assign aif.set = {tif.set, 2'b00, curr_alert_in, volt_alert_in};
  assign aif.clr = s.clr;

  // ------------------------------------------------------------
  // Handshake outputs
  // ------------------------------------------------------------
  // One write and one read at a time; new write beats wait until the write response is accepted, a new read until its data is accepted
  // A beat held for its partner blocks a second beat on that channel
  assign awready_out = !s.aw_hold && !s.bvalid;
  assign wready_out = !s.w_hold && !s.bvalid;
  assign arready_out = !s.rvalid;

  // ------------------------------------------------------------
  // Bus and register logic
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    n.code_load = 4'h0;
    n.clr = 24'h000000;
    cfg_new = s.cfg;
    code_new = 16'h0000;
    rd = 17'h00000;

    // ------------------------------------------------------------
    // Write address and data
    // ------------------------------------------------------------
    // Address and data may come in either order
    if (awvalid_in && awready_out) begin
      n.aw_hold = 1'b1;
      n.aw_idx = awaddr_in[7:2];
    end
    if (wvalid_in && wready_out) begin
      n.w_hold = 1'b1;
      n.wdata = wdata_in[15:0];
      n.wstrb = wstrb_in[1:0];
    end

    // ------------------------------------------------------------
    // Write commit
    // ------------------------------------------------------------
    if (s.aw_hold && s.w_hold) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = idx_ok(s.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      if (is_code_idx(s.aw_idx)) begin
        // Writes here reach the converters; reads of indices 2 to 4 show results, index 1 reads zero
        code_new = merge16({4'h0, s.code[code_slot(s.aw_idx)]}, s.wdata, s.wstrb);
        // The top nibble is dropped, so a converter never sees it
        n.code[code_slot(s.aw_idx)] = code_new[`CODE_W-1:0];
        n.code_load[code_slot(s.aw_idx)] = |s.wstrb;
      end
      // Alert registers are write-one-clear; a set in the same cycle wins
      unique case (s.aw_idx)
        `IDX_ALERT_A: begin
          n.clr[7:0] = clear_bits(s.wdata, s.wstrb, 8'hff);
        end
        `IDX_ALERT_B: begin
          n.clr[15:8] = clear_bits(s.wdata, s.wstrb, `ALERT_B_MASK);
        end
        `IDX_ALERT_C: begin
          n.clr[23:16] = clear_bits(s.wdata, s.wstrb, 8'hff);
        end
        `IDX_SEQ: begin
          if (s.wstrb[0]) begin
            n.seq = s.wdata[5:0];
          end
        end
        `IDX_CFG: begin
          cfg_new = merge16(s.cfg, s.wdata, s.wstrb);
          n.cfg = cfg_new;
          // Both bits set wipes every alert register
          if (cfg_new[`CFG_BIT_CLR] && cfg_new[`CFG_BIT_PIN]) begin
            n.clr = 24'hffffff;
          end
        end
        default: begin
          n.clr = 24'h000000;
        end
      endcase
    end

    if (s.bvalid && bready_in) begin
      n.bvalid = 1'b0;
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    if (s.rvalid && rready_in) begin
      n.rvalid = 1'b0;
    end
    if (arvalid_in && arready_out) begin
      rd = rd_word(araddr_in[7:2], tif.word, aif.status, s.seq, s.cfg);
      n.rvalid = 1'b1;
      n.rdata = rd[15:0];
      n.rresp = rd[16] ? `RESP_SLVERR : `RESP_OKAY;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
      // Configuration comes up cleared, so the alert pin starts disabled
      s.cfg <= `CFG_RESET;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bvalid_out = s.bvalid;
  assign bresp_out = s.bresp;
  assign rvalid_out = s.rvalid;
  assign rresp_out = s.rresp;
  // Narrow registers sit in the low bits, upper lanes read zero
  assign rdata_out = {16'h0000, s.rdata};

  // ------------------------------------------------------------
  // Converter codes
  // ------------------------------------------------------------
  assign output_converter_a_out = s.code[0];
  assign output_converter_b_out = s.code[1];
  assign output_converter_c_out = s.code[2];
  assign output_converter_d_out = s.code[3];
  assign code_load_out = s.code_load;

  // ------------------------------------------------------------
  // Mode outputs
  // ------------------------------------------------------------
  assign channel_select_out = s.seq;
  assign config_out = s.cfg;
  assign autocycle_enable_out = s.cfg[`CFG_BIT_AUTO];
  assign alert_pin_enable_out = s.cfg[`CFG_BIT_PIN];
endmodule

// File: sim/monitor_result_alert_regs_props.sv
// Port checks of the monitor register bank
`timescale 1ns/1ps
module monitor_result_alert_regs_props #(
  parameter int REFRESH_CYCLES = 200000
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Bus
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [7:0] araddr_in,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic bvalid_out,
  // Outputs
  input wire logic [3:0] code_load_out,
  input wire logic [11:0] output_converter_a_out,
  input wire logic [2:0] conv_request_out,
  input wire logic [15:0] config_out,
  input wire logic alert_pin_enable_out
);
  logic [5:0] idx_r;
  int gap_r;
  logic seen_r;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // ----
  // Read index and request spacing
  // ----
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_r <= 6'h00;
      gap_r <= 0;
      seen_r <= 1'b0;
    end else begin
      if (arvalid_in && arready_out) begin
        idx_r <= araddr_in[7:2];
      end
      gap_r <= conv_request_out[0] ? 1 : gap_r + 1;
      seen_r <= seen_r | conv_request_out[0];
    end
  end
  AST_RD_LAT: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read data late");
  AST_RD_DROP: assert property (rvalid_out && rready_in |=> !rvalid_out)
    else $error("read data held after handshake");
  AST_DIODE_TAG: assert property (rvalid_out && idx_r inside {2, 3} |->
    rdata_out[14:12] == {2'b11, idx_r[0]})
    else $error("wrong channel tag");
  AST_INT_PAD: assert property (rvalid_out && idx_r == 6'h04 |-> rdata_out[14:11] == 4'h0)
    else $error("internal result pad not zero");
  AST_RSV_ZERO: assert property (rvalid_out && idx_r inside {6, 8} |-> rdata_out[7:6] == 2'b00)
    else $error("reserved bits not zero");
  AST_LOAD: assert property (code_load_out != 4'h0 |-> bvalid_out ##1 code_load_out == 4'h0)
    else $error("code load pulse wrong");
  AST_CODE_A: assert property ($changed(output_converter_a_out) |-> code_load_out[0])
    else $error("code changed without write");
  AST_REQ_ALL: assert property (conv_request_out != 3'b000 |-> conv_request_out == 3'b111)
    else $error("refresh not on all channels");
  AST_REQ_GAP: assert property (conv_request_out[0] && seen_r |-> gap_r == REFRESH_CYCLES)
    else $error("refresh spacing wrong");
  AST_PIN: assert property ($changed(config_out) |-> $rose(bvalid_out) &&
    alert_pin_enable_out == config_out[2])
    else $error("config changed outside a write or pin enable wrong");
endmodule

bind monitor_result_alert_regs monitor_result_alert_regs_props #(
  .REFRESH_CYCLES(REFRESH_CYCLES)
) u_props (
  .clock_in(clock_in), .resetn_in(resetn_in), .arvalid_in(arvalid_in),
  .arready_out(arready_out), .araddr_in(araddr_in), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .rdata_out(rdata_out), .bvalid_out(bvalid_out),
  .code_load_out(code_load_out), .output_converter_a_out(output_converter_a_out),
  .conv_request_out(conv_request_out), .config_out(config_out),
  .alert_pin_enable_out(alert_pin_enable_out)
);

// File: sim/axi_host_model.sv
// Bus-master model of the host that reaches the register bank
`timescale 1ns/1ps
module axi_host_model (
  // Clock
  input wire logic clock_in,
  // Write channels
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [7:0] awaddr_out,
  output logic wvalid_out,
  input wire logic wready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  input wire logic bvalid_in,
  output logic bready_out,
  input wire logic [1:0] bresp_in,
  // Read channels
  output logic arvalid_out,
  input wire logic arready_in,
  output logic [7:0] araddr_out,
  input wire logic rvalid_in,
  output logic rready_out,
  input wire logic [31:0] rdata_in
);
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, araddr_out, wdata_out, wstrb_out} = 52'h0;
  end
  task automatic write(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] resp);
    logic aw_busy;
    logic w_busy;
    @(posedge clock_in);
    {awvalid_out, wvalid_out, bready_out} <= 3'b111;
    awaddr_out <= {idx, 2'b00};
    wdata_out <= d;
    wstrb_out <= s;
    {aw_busy, w_busy} = 2'b11;
    while (aw_busy || w_busy) begin
      @(posedge clock_in);
      if (aw_busy && awready_in) begin
        aw_busy = 1'b0;
        awvalid_out <= 1'b0;
        awaddr_out <= ~awaddr_out;
      end
      if (w_busy && wready_in) begin
        w_busy = 1'b0;
        wvalid_out <= 1'b0;
        wdata_out <= ~wdata_out;
      end
    end
    while (bvalid_in !== 1'b1) begin
      @(posedge clock_in);
    end
    resp = bresp_in;
    bready_out <= 1'b0;
  endtask
  task automatic read(input logic [5:0] idx, output logic [31:0] d);
    @(posedge clock_in);
    {arvalid_out, rready_out} <= 2'b11;
    araddr_out <= {idx, 2'b00};
    do @(posedge clock_in); while (arready_in !== 1'b1);
    arvalid_out <= 1'b0;
    araddr_out <= ~araddr_out;
    do @(posedge clock_in); while (rvalid_in !== 1'b1);
    d = rdata_in;
    rready_out <= 1'b0;
  endtask
endmodule

// File: sim/monitor_result_alert_regs_bench.sv
// Self-checking bench of the monitor register bank
`timescale 1ns/1ps
module monitor_result_alert_regs_bench;
  localparam int REFRESH = 16;
  logic clock_in, resetn_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cv_done, auto_en, pin_en;
  logic [7:0] awaddr, araddr, volt;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cv_q;
  logic [1:0] bresp, rresp, cv_chan;
  logic [10:0] cv_val;
  logic [5:0] curr, sel;
  logic [2:0] req;
  logic [11:0] code [4];
  logic [15:0] cfg;
  int num_errors = 0;
  int n_checks = 0;
  monitor_result_alert_regs #(.REFRESH_CYCLES(REFRESH)) u_dut (
    .clock_in(clock_in), .resetn_in(resetn_in),
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr),
    .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb),
    .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
    .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
    .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
    .conv_done_in(cv_done), .conv_chan_in(cv_chan), .conv_value_in(cv_val),
    .conv_low_in(cv_q[3]), .conv_high_in(cv_q[2]), .conv_open_in(cv_q[1]),
    .conv_overtemp_in(cv_q[0]), .volt_alert_in(volt), .curr_alert_in(curr),
    .conv_request_out(req), .output_converter_a_out(code[0]),
    .output_converter_b_out(code[1]), .output_converter_c_out(code[2]),
    .output_converter_d_out(code[3]), .code_load_out(), .channel_select_out(sel),
    .config_out(cfg), .autocycle_enable_out(auto_en), .alert_pin_enable_out(pin_en)
  );
  axi_host_model u_host (
    .clock_in(clock_in), .awvalid_out(awvalid), .awready_in(awready),
    .awaddr_out(awaddr), .wvalid_out(wvalid), .wready_in(wready), .wdata_out(wdata),
    .wstrb_out(wstrb), .bvalid_in(bvalid), .bready_out(bready), .bresp_in(bresp),
    .arvalid_out(arvalid), .arready_in(arready), .araddr_out(araddr),
    .rvalid_in(rvalid), .rready_out(rready), .rdata_in(rdata)
  );
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // ----
  // Checks and bus helpers
  // ----
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    u_host.read(idx, d);
    chk_word($sformatf("register %0d", idx), exp, d);
    chk_resp("read response", 2'b00, rresp);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    u_host.write(idx, d, s, r);
    chk_resp("write response", 2'b00, r);
  endtask
  task automatic conv(input logic [1:0] ch, input logic [10:0] v, input logic [3:0] q);
    @(posedge clock_in);
    {cv_done, cv_chan, cv_val, cv_q} <= {1'b1, ch, v, q};
    @(posedge clock_in);
    cv_done <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clock_in);
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int n;
    {resetn_in, cv_done, cv_chan, cv_val, cv_q, volt, curr} = 0;
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(6'h09, 32'h0);
    $display("test reset done");
    conv(2'd0, 11'h7ff, 4'b1001);
    conv(2'd1, 11'h190, 4'b0010);
    conv(2'd2, 11'h064, 4'b0100);
    rd(6'h02, 32'he7ff);
    rd(6'h03, 32'hf990);
    rd(6'h04, 32'h8064);
    rd(6'h07, 32'he1);
    conv(2'd0, 11'h000, 4'b0000);
    rd(6'h02, 32'h6000);
    rd(6'h07, 32'he1);
    $display("test results done");
    wr(6'h07, 32'h01, 4'h1);
    rd(6'h07, 32'he0);
    wr(6'h07, 32'hff, 4'h1);
    rd(6'h07, 32'h00);
    @(posedge clock_in);
    {volt, curr} <= 14'h3fff;
    @(posedge clock_in);
    {volt, curr} <= 14'h0;
    rd(6'h05, 32'hff);
    rd(6'h06, 32'h3f);
    conv(2'd2, 11'h000, 4'b1000);
    wr(6'h09, 32'h0006, 4'h3);
    rd(6'h05, 32'h0);
    rd(6'h06, 32'h0);
    rd(6'h07, 32'h0);
    chk_word("alert pin enable", 32'h1, {31'h0, pin_en});
    wr(6'h08, 32'hff, 4'h1);
    rd(6'h08, 32'h3f);
    chk_word("channel select", 32'h3f, {26'h0, sel});
    $display("test alerts done");
    for (int i = 0; i < 4; i++) begin
      wr(6'(i + 1), 32'hf000 | (32'h111 * 32'(i + 1)), 4'h3);
      chk_word("converter code", 32'h111 * 32'(i + 1), {20'h0, code[i]});
    end
    $display("test converters done");
    wr(6'h09, 32'h1200, 4'h2);
    rd(6'h09, 32'h1206);
    chk_word("autocycle enable", 32'h1, {31'h0, auto_en});
    chk_word("config out", 32'h1206, {16'h0, cfg});
    u_host.write(6'h0a, 32'h0, 4'h1, r);
    chk_resp("unmapped write", 2'b10, r);
    u_host.read(6'h00, d);
    chk_resp("unmapped read", 2'b10, rresp);
    $display("test lanes done");
    n = 0;
    while (req !== 3'b111 && n < 4 * REFRESH) begin
      @(posedge clock_in);
      n++;
    end
    chk_word("refresh request", 32'h7, {29'h0, req});
    $display("test refresh done");
    give_verdict();
  end
endmodule
